// file: spi_dma_map.vh
/*
 spi_dma_map.vh: constants for the serial port DMA and error logic.
 assumes it is included by bare name from the design files.
*/
`ifndef SPI_DMA_MAP_VH
`define SPI_DMA_MAP_VH
`define WORD_W 16
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define CNT_W 16
`define HALF_PERIOD_DIV 3'h7
`define BIT_CNT_W 5
`endif

// file: pin_sync.v
/*
 pin_sync.v: three-stage synchroniser with agreement filter for pins.
 assumes a level input from outside the clk domain.
*/
`default_nettype none
module pin_sync (
   input wire clk,
   input wire resetn,
   input wire pin_in,
   input wire init_val,
   output reg level_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // first stage feeds only the second stage
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
   wire unused_init = init_val;
endmodule
`default_nettype wire

// file: spi_dma_port.v
/*
 spi_dma_port.v: serial port datapath for DMA transfers, master and slave,
 with the tx/rx flow control and the four error flags.
 assumes the dma engine pushes tx words and pops rx words by valid/ready,
 and that the word counter lives in the dma engine (dma_cnt_one_to_zero).
 link pins arrive asynchronously and are sampled by clk.
*/
`default_nettype none
`include "spi_dma_map.vh"

module spi_dma_port (
   input wire clk,
   input wire resetn,
   input wire port_enable_wr,
   input wire port_enable_in,
   input wire master_select_wr,
   input wire master_select_in,
   input wire fault_detect_enable,
   input wire clk_phase,
   input wire clk_polarity,
   input wire overwrite_when_full,
   input wire send_zero_when_empty,
   input wire dma_enable,
   input wire dma_dir_tx,
   input wire dma_err_irq_en,
   input wire dma_done_irq_en,
   input wire dma_cnt_one_to_zero,
   input wire [`WORD_W-1:0] tx_buffer_wdata,
   input wire tx_buffer_we,
   input wire rx_buffer_re,
   input wire [3:0] status_w1c,
   input wire [`WORD_W-1:0] dma_tx_data,
   input wire dma_tx_valid,
   output wire dma_tx_ready,
   output reg [`WORD_W-1:0] dma_rx_data,
   output wire dma_rx_valid,
   input wire dma_rx_ready,
   input wire master_start,
   input wire sclk_in,
   input wire slave_select_input,
   input wire miso_in,
   input wire mosi_in,
   output reg sclk_out,
   output wire sclk_oe,
   output wire mosi_out,
   output wire mosi_oe,
   output wire miso_out,
   output wire miso_oe,
   output wire select_by_flags,
   output reg port_enable_q,
   output reg master_select_q,
   output reg [`WORD_W-1:0] rx_buffer,
   output reg tx_buffer_full_flag,
   output reg rx_buffer_full_flag,
   output reg tx_underflow_flag,
   output reg rx_overrun_flag,
   output reg tx_collision_flag,
   output reg mode_fault_flag,
   output reg port_irq,
   output reg dma_irq
);
   // fifo storage shared by tx and rx, direction picked by dma_dir_tx
   reg [`WORD_W-1:0] fifo_mem [0:`FIFO_DEPTH-1];
   reg [`FIFO_AW:0] wr_ptr_q;
   reg [`FIFO_AW:0] rd_ptr_q;
   reg [`WORD_W-1:0] tx_buffer;
   reg [`WORD_W-1:0] shift_q;
   reg [`WORD_W-1:0] last_tx_q;
   reg [`BIT_CNT_W-1:0] bit_cnt_q;
   reg [1:0] state_q;
   reg sclk_prev_q;
   reg ss_prev_q;
   reg [2:0] div_q;
   wire sclk_s;
   wire ss_s;
   wire mosi_s;
   wire miso_s;
   wire fifo_full = (wr_ptr_q[`FIFO_AW] != rd_ptr_q[`FIFO_AW]) &&
                    (wr_ptr_q[`FIFO_AW-1:0] == rd_ptr_q[`FIFO_AW-1:0]);
   wire fifo_empty = (wr_ptr_q == rd_ptr_q);
   wire tx_dma = dma_enable & dma_dir_tx;
   wire rx_dma = dma_enable & ~dma_dir_tx;
   localparam ST_IDLE = 2'h0;
   localparam ST_SHIFT = 2'h1;
   localparam ST_DONE = 2'h2;
   // count end is latched: the engine's pulse alone would let the next select restart
   reg cnt_done_q;
   wire stop_words = dma_cnt_one_to_zero | cnt_done_q;

   pin_sync u_sclk (.clk(clk), .resetn(resetn), .pin_in(sclk_in), .init_val(1'b0), .level_q(sclk_s));
   pin_sync u_ss (.clk(clk), .resetn(resetn), .pin_in(slave_select_input), .init_val(1'b1), .level_q(ss_s));
   pin_sync u_mosi (.clk(clk), .resetn(resetn), .pin_in(mosi_in), .init_val(1'b0), .level_q(mosi_s));
   pin_sync u_miso (.clk(clk), .resetn(resetn), .pin_in(miso_in), .init_val(1'b0), .level_q(miso_s));

   function [`FIFO_AW:0] ptr_inc;
      input [`FIFO_AW:0] p;
      begin
         ptr_inc = p + {{`FIFO_AW{1'b0}}, 1'b1};
      end
   endfunction

   wire active = port_enable_q;
   wire is_master = master_select_q;
   // sync filter holds ss low after reset; treat as deselected until seen high once
   reg ss_seen_q;
   wire selected = ~ss_s & ss_seen_q;
   // master makes the link clock from clk by a divider
   wire m_tick = is_master && (div_q == `HALF_PERIOD_DIV);
   wire s_rise = sclk_s & ~sclk_prev_q;
   wire s_fall = ~sclk_s & sclk_prev_q;
   wire s_lead = clk_polarity ? s_fall : s_rise;
   wire s_trail = clk_polarity ? s_rise : s_fall;
   wire slave_go = active & ~is_master & selected;
   wire ss_fall = ~ss_s & ss_prev_q & ss_seen_q;
   wire lead = is_master ? (m_tick & (sclk_out == clk_polarity)) : (slave_go & s_lead);
   wire trail = is_master ? (m_tick & (sclk_out != clk_polarity)) : (slave_go & s_trail);
   wire sample_edge = clk_phase ? trail : lead;
   wire change_edge = clk_phase ? lead : trail;
   wire data_in = is_master ? miso_s : mosi_s;
   wire start_req = active & (state_q == ST_IDLE) & ~stop_words & dma_enable &
                    (is_master ? master_start : (ss_fall | (selected & s_lead)));
   // edges seen while idle must never complete a word
   wire word_done = sample_edge & (state_q == ST_SHIFT) & (bit_cnt_q == (`WORD_W - 1));
   wire load_shift = start_req | (word_done & (is_master ? master_start : selected) & ~stop_words);
   wire tx_have = tx_dma ? ~fifo_empty : tx_buffer_full_flag;
   wire tx_pop = load_shift & tx_dma & ~fifo_empty;
   wire rx_push = word_done & rx_dma;
   wire rx_pop = dma_rx_valid & dma_rx_ready;
   wire fault = fault_detect_enable & master_select_q & ~ss_s & ss_seen_q;
   reg [`WORD_W-1:0] load_val;
   reg [`WORD_W-1:0] rx_word;

   assign dma_tx_ready = tx_dma & ~fifo_full;
   assign dma_rx_valid = rx_dma & ~fifo_empty;
   assign mosi_out = shift_q[`WORD_W-1];
   assign miso_out = shift_q[`WORD_W-1];
   assign mosi_oe = active & is_master;
   assign miso_oe = active & ~is_master & selected;
   assign sclk_oe = active & is_master;
   assign select_by_flags = ~(active & is_master);

   always @* begin
      rx_word = {shift_q[`WORD_W-2:0], data_in};
      if (tx_dma) begin
         if (!fifo_empty) begin
            load_val = fifo_mem[rd_ptr_q[`FIFO_AW-1:0]];
         end else if (send_zero_when_empty) begin
            load_val = {`WORD_W{1'b0}};
         end else begin
            load_val = last_tx_q;
         end
      end else if (rx_dma) begin
         load_val = send_zero_when_empty ? {`WORD_W{1'b0}} : tx_buffer;
      end else begin
         load_val = (tx_buffer_full_flag | ~send_zero_when_empty) ? tx_buffer : {`WORD_W{1'b0}};
      end
   end

   always @(posedge clk) begin
      if (tx_dma && dma_tx_valid && !fifo_full) begin
         fifo_mem[wr_ptr_q[`FIFO_AW-1:0]] <= dma_tx_data;
      end else if (rx_push && (!fifo_full || overwrite_when_full)) begin
         fifo_mem[wr_ptr_q[`FIFO_AW-1:0]] <= rx_word;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_q <= {(`FIFO_AW+1){1'b0}};
         rd_ptr_q <= {(`FIFO_AW+1){1'b0}};
         state_q <= ST_IDLE;
         cnt_done_q <= 1'b0;
         bit_cnt_q <= {`BIT_CNT_W{1'b0}};
         shift_q <= {`WORD_W{1'b0}};
         last_tx_q <= {`WORD_W{1'b0}};
         tx_buffer <= {`WORD_W{1'b0}};
         rx_buffer <= {`WORD_W{1'b0}};
         dma_rx_data <= {`WORD_W{1'b0}};
         sclk_out <= 1'b0;
         sclk_prev_q <= 1'b0;
         ss_prev_q <= 1'b1;
         ss_seen_q <= 1'b0;
         div_q <= 3'h0;
         port_enable_q <= 1'b0;
         master_select_q <= 1'b0;
         tx_buffer_full_flag <= 1'b0;
         rx_buffer_full_flag <= 1'b0;
         tx_underflow_flag <= 1'b0;
         rx_overrun_flag <= 1'b0;
         tx_collision_flag <= 1'b0;
         mode_fault_flag <= 1'b0;
         port_irq <= 1'b0;
         dma_irq <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         ss_prev_q <= ss_s;
         if (ss_s) begin
            ss_seen_q <= 1'b1;
         end
         if (!dma_enable) begin
            cnt_done_q <= 1'b0;
         end else if (dma_cnt_one_to_zero) begin
            cnt_done_q <= 1'b1;
         end
         div_q <= (active && is_master && state_q == ST_SHIFT) ? div_q + 3'h1 : 3'h0;
         if (!dma_enable) begin
            wr_ptr_q <= {(`FIFO_AW+1){1'b0}};
            rd_ptr_q <= {(`FIFO_AW+1){1'b0}};
         end else if (tx_dma) begin
            if (dma_tx_valid && !fifo_full) begin
               wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if (tx_pop) begin
               rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
         end else begin
            // full fifo: overwrite drops the oldest entry, else the new word is lost
            if (rx_push && (!fifo_full || overwrite_when_full)) begin
               wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if ((rx_pop) || (rx_push && fifo_full && overwrite_when_full)) begin
               rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
         end
         dma_rx_data <= fifo_mem[rd_ptr_q[`FIFO_AW-1:0]];
         case (state_q)
            ST_IDLE: begin
               sclk_out <= clk_polarity;
               if (start_req) begin
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (m_tick) begin
                  sclk_out <= ~sclk_out;
               end
               if (!active || (!is_master && !selected)) begin
                  state_q <= ST_IDLE;
               end else if (word_done && !load_shift) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               sclk_out <= clk_polarity;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
         if (load_shift) begin
            shift_q <= load_val;
            last_tx_q <= load_val;
            bit_cnt_q <= {`BIT_CNT_W{1'b0}};
         end else if (sample_edge) begin
            shift_q <= {shift_q[`WORD_W-2:0], data_in};
            bit_cnt_q <= bit_cnt_q + 5'h1;
         end
         if (tx_buffer_we) begin
            tx_buffer <= tx_buffer_wdata;
         end
         // set wins over clear for every flag
         if (tx_buffer_we) begin
            tx_buffer_full_flag <= 1'b1;
         end else if (load_shift && !tx_dma) begin
            tx_buffer_full_flag <= 1'b0;
         end
         if (load_shift && (rx_dma || !tx_have)) begin
            tx_underflow_flag <= 1'b1;
         end else if (status_w1c[0]) begin
            tx_underflow_flag <= 1'b0;
         end
         if (word_done && !tx_dma) begin
            if (!rx_buffer_full_flag || rx_buffer_re || overwrite_when_full) begin
               rx_buffer <= rx_word;
            end
            rx_buffer_full_flag <= 1'b1;
         end else if (rx_buffer_re) begin
            rx_buffer_full_flag <= 1'b0;
         end
         // a clear must still land when a word completes without overrun
         if (word_done && !tx_dma && rx_buffer_full_flag && !rx_buffer_re) begin
            rx_overrun_flag <= 1'b1;
         end else if (status_w1c[1]) begin
            rx_overrun_flag <= 1'b0;
         end
         if (load_shift && (tx_buffer_we || (tx_dma && dma_tx_valid)) && (is_master || clk_phase)) begin
            tx_collision_flag <= 1'b1;
         end else if (status_w1c[2]) begin
            tx_collision_flag <= 1'b0;
         end
         if (fault) begin
            mode_fault_flag <= 1'b1;
            port_enable_q <= 1'b0;
            master_select_q <= 1'b0;
         end else begin
            if (status_w1c[3]) begin
               mode_fault_flag <= 1'b0;
            end
            // writes of one are refused while the fault stands
            if (port_enable_wr && !(port_enable_in && mode_fault_flag)) begin
               port_enable_q <= port_enable_in;
            end
            if (master_select_wr && !(master_select_in && mode_fault_flag)) begin
               master_select_q <= master_select_in;
            end
         end
         port_irq <= fault | (mode_fault_flag & ~status_w1c[3]);
         // dma mode errors only from the active direction, gated by descriptor config
         dma_irq <= dma_enable & ((dma_done_irq_en & dma_cnt_one_to_zero) |
                    (dma_err_irq_en & ((tx_dma & load_shift & fifo_empty) |
                    (rx_dma & rx_push & fifo_full))));
      end
   end
endmodule
`default_nettype wire

// file: spi_port_sva.sv
/* spi_port_sva.sv: port assertions for spi_dma_port, bound after the module.
   assumes one clk domain with async active-low resetn. */
`default_nettype none
module spi_port_sva (
   input wire logic clk,
   input wire logic resetn,
   input wire logic port_enable_wr,
   input wire logic port_enable_in,
   input wire logic fault_detect_enable,
   input wire logic [3:0] status_w1c,
   input wire logic tx_buffer_we,
   input wire logic slave_select_input,
   input wire logic sclk_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic select_by_flags,
   input wire logic port_enable_q,
   input wire logic master_select_q,
   input wire logic tx_buffer_full_flag,
   input wire logic mode_fault_flag,
   input wire logic port_irq,
   input wire logic dma_enable,
   input wire logic dma_dir_tx,
   input wire logic dma_cnt_one_to_zero,
   input wire logic dma_rx_valid,
   input wire logic dma_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // two idle cycles give the pin enables room for one register stage
   sequence port_off;
      (!port_enable_q && !master_select_q) [*2];
   endsequence
   sequence fault_armed;
      port_enable_q && master_select_q && fault_detect_enable && !slave_select_input;
   endsequence
   chk_fault_seen: assert property (fault_armed |-> ##[1:8] mode_fault_flag)
      else $error("mode fault missed");
   chk_fault_drops: assert property ($rose(mode_fault_flag) |-> ##[0:1] !port_enable_q && !master_select_q)
      else $error("control kept on fault");
   chk_fault_irq: assert property ($rose(mode_fault_flag) |-> ##[0:1] port_irq)
      else $error("no port irq on fault");
   chk_irq_clear: assert property ($fell(mode_fault_flag) |-> ##[0:1] !port_irq)
      else $error("port irq kept after clear");
   chk_fault_refuse: assert property (mode_fault_flag && !status_w1c[3] && port_enable_wr
      && port_enable_in |=> !port_enable_q) else $error("enable taken during fault");
   chk_zero_keeps: assert property (mode_fault_flag && !status_w1c[3] |=> mode_fault_flag)
      else $error("fault flag lost");
   chk_tx_full: assert property (tx_buffer_we |=> tx_buffer_full_flag)
      else $error("tx full flag not set");
   chk_pins_off: assert property (port_off |-> !sclk_oe && !mosi_oe && !miso_oe && select_by_flags)
      else $error("pins driven while off");
   chk_irq_quiet: assert property (!mode_fault_flag [*2] |-> !port_irq)
      else $error("port irq without fault");
   // empty rx fifo cannot overflow, and the tx underflow term needs tx_dma, so no error irq can come here
   chk_rx_err_quiet: assert property (dma_enable && !dma_dir_tx && !dma_cnt_one_to_zero && !dma_rx_valid
      |=> !dma_irq) else $error("error irq from rx dma underflow");
endmodule
bind spi_dma_port spi_port_sva u_sva (.clk, .resetn, .port_enable_wr, .port_enable_in, .fault_detect_enable,
   .status_w1c, .tx_buffer_we, .slave_select_input, .sclk_oe, .mosi_oe, .miso_oe, .select_by_flags,
   .port_enable_q, .master_select_q, .tx_buffer_full_flag, .mode_fault_flag, .port_irq,
   .dma_enable, .dma_dir_tx, .dma_cnt_one_to_zero, .dma_rx_valid, .dma_irq);
`default_nettype wire

// file: ext_master_model.sv
/* ext_master_model.sv: far-end serial master sending one 16-bit word per go.
   assumes clock phase 0, idle-low serial clock of 125 ns period. */
`default_nettype none
module ext_master_model (
   input wire logic go,
   input wire logic [15:0] word,
   input wire logic miso,
   output logic ss_n,
   output logic sclk,
   output logic mosi,
   output logic [15:0] got,
   output logic done
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      ss_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      got = 16'h0000;
      done = 1'b0;
      forever begin
         wait (go);
         ss_n = 1'b0;
         for (int i = 15; i >= 0; i--) begin
            mosi = word[i];
            #62.5 sclk = 1'b1;
            got = {got[14:0], miso};
            #62.5 sclk = 1'b0;
         end
         #62.5 ss_n = 1'b1;
         // released line has no pull: show a changed level, not the last bit
         mosi = ~mosi;
         done = 1'b1;
         wait (!go);
         done = 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: tb.sv
/* tb.sv: bench for spi_dma_port: master mode fault, then slave receive dma.
   assumes ext_master_model and the checker are compiled first. */
`default_nettype none
`include "spi_dma_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, resetn, port_enable_wr, port_enable_in, master_select_wr, master_select_in, fault_detect_enable;
   logic clk_phase, clk_polarity, overwrite_when_full, send_zero_when_empty, dma_enable, dma_dir_tx;
   logic dma_err_irq_en, dma_done_irq_en, dma_cnt_one_to_zero, tx_buffer_we, rx_buffer_re, dma_tx_valid;
   logic dma_rx_ready, master_start, fault_ss_n, go;
   logic [3:0] status_w1c;
   logic [`WORD_W-1:0] tx_buffer_wdata, dma_tx_data, word;
   wire [`WORD_W-1:0] got, dma_rx_data, rx_buffer;
   wire dma_tx_ready, dma_rx_valid, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, select_by_flags;
   wire port_enable_q, master_select_q, tx_buffer_full_flag, rx_buffer_full_flag, tx_underflow_flag;
   wire rx_overrun_flag, tx_collision_flag, mode_fault_flag, port_irq, dma_irq, ss_n, sclk_in, mosi_in, done;
   wire slave_select_input = ss_n & fault_ss_n;
   wire miso_in = miso_oe ? miso_out : ~mosi_in;
   int errors = 0;
   int checks_done = 0;
   spi_dma_port DUT (.clk, .resetn, .port_enable_wr, .port_enable_in, .master_select_wr, .master_select_in,
      .fault_detect_enable, .clk_phase, .clk_polarity, .overwrite_when_full, .send_zero_when_empty, .dma_enable,
      .dma_dir_tx, .dma_err_irq_en, .dma_done_irq_en, .dma_cnt_one_to_zero, .tx_buffer_wdata, .tx_buffer_we,
      .rx_buffer_re, .status_w1c, .dma_tx_data, .dma_tx_valid, .dma_tx_ready, .dma_rx_data, .dma_rx_valid,
      .dma_rx_ready, .master_start, .sclk_in, .slave_select_input, .miso_in, .mosi_in, .sclk_out, .sclk_oe,
      .mosi_out, .mosi_oe, .miso_out, .miso_oe, .select_by_flags, .port_enable_q, .master_select_q, .rx_buffer,
      .tx_buffer_full_flag, .rx_buffer_full_flag, .tx_underflow_flag, .rx_overrun_flag, .tx_collision_flag,
      .mode_fault_flag, .port_irq, .dma_irq);
   ext_master_model far_end (.go, .word, .miso(miso_in), .ss_n, .sclk(sclk_in), .mosi(mosi_in), .got, .done);
   always #2 clk = ~clk;
   task automatic test_done();
      if (errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic timeout();
      errors++;
      test_done();
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic set_ctl(input logic en, input logic ms);
      port_enable_wr = 1'b1;
      port_enable_in = en;
      master_select_wr = 1'b1;
      master_select_in = ms;
      cyc(1);
      port_enable_wr = 1'b0;
      master_select_wr = 1'b0;
   endtask
   task automatic w1c(input logic [3:0] m);
      status_w1c = m;
      cyc(1);
      status_w1c = 4'h0;
      cyc(1);
   endtask
   task automatic frame(input logic [15:0] w);
      int k;
      word = w;
      go = 1'b1;
      for (k = 0; k < 2000 && done !== 1'b1; k++) cyc(1);
      if (k == 2000) timeout();
      go = 1'b0;
      cyc(4);
   endtask
   // the far side stalls: one pop per call, data read before ready is raised
   task automatic pop(input logic [15:0] exp);
      int k;
      for (k = 0; k < 100 && dma_rx_valid !== 1'b1; k++) cyc(1);
      if (k == 100) timeout();
      cyc(1);
      chk("dma_rx_data", dma_rx_data, exp);
      dma_rx_ready = 1'b1;
      cyc(1);
      dma_rx_ready = 1'b0;
      cyc(2);
   endtask
   initial begin
      int i;
      {clk, resetn, port_enable_wr, port_enable_in, master_select_wr, master_select_in, fault_detect_enable} = '0;
      {clk_phase, clk_polarity, overwrite_when_full, send_zero_when_empty, dma_enable, dma_dir_tx} = '0;
      {dma_err_irq_en, dma_done_irq_en, dma_cnt_one_to_zero, tx_buffer_we, rx_buffer_re, dma_tx_valid} = '0;
      {dma_rx_ready, master_start, go, tx_buffer_wdata, dma_tx_data, word, status_w1c} = '0;
      fault_ss_n = 1'b1;
      cyc(4);
      resetn = 1'b1;
      cyc(8);
      chk("select_by_flags", select_by_flags, 1'b1);
      fault_detect_enable = 1'b1;
      clk_phase = 1'b1;
      dma_dir_tx = 1'b1;
      chk("slave_select_input", slave_select_input, 1'b1);
      set_ctl(1'b1, 1'b1);
      cyc(2);
      fault_ss_n = 1'b0;
      for (i = 0; i < 20 && mode_fault_flag !== 1'b1; i++) cyc(1);
      if (i == 20) timeout();
      cyc(2);
      chk("port_enable_q", port_enable_q, 1'b0);
      chk("master_select_q", master_select_q, 1'b0);
      chk("port_irq", port_irq, 1'b1);
      set_ctl(1'b1, 1'b1);
      cyc(2);
      chk("port_enable_q", port_enable_q, 1'b0);
      w1c(4'h7);
      chk("mode_fault_flag", mode_fault_flag, 1'b1);
      fault_ss_n = 1'b1;
      w1c(4'h8);
      cyc(1);
      chk("port_irq", port_irq, 1'b0);
      fault_detect_enable = 1'b0;
      clk_phase = 1'b0;
      dma_dir_tx = 1'b0;
      send_zero_when_empty = 1'b1;
      dma_err_irq_en = 1'b1;
      dma_done_irq_en = 1'b1;
      set_ctl(1'b1, 1'b0);
      dma_enable = 1'b1;
      cyc(2);
      frame(16'h1234);
      chk("miso word", got, 16'h0000);
      chk("tx_underflow_flag", tx_underflow_flag, 1'b1);
      chk("dma_irq", dma_irq, 1'b0);
      chk("rx_buffer", rx_buffer, 16'h1234);
      w1c(4'h1);
      chk("tx_underflow_flag", tx_underflow_flag, 1'b0);
      pop(16'h1234);
      // write held across the frame start: a slave with clock phase 0 must not flag it
      tx_buffer_wdata = 16'hA5C3;
      tx_buffer_we = 1'b1;
      cyc(1);
      chk("tx_buffer_full_flag", tx_buffer_full_flag, 1'b1);
      send_zero_when_empty = 1'b0;
      frame(16'h5A0F);
      tx_buffer_we = 1'b0;
      chk("miso word", got, 16'hA5C3);
      chk("tx_collision_flag", tx_collision_flag, 1'b0);
      chk("rx_overrun_flag", rx_overrun_flag, 1'b1);
      chk("rx_buffer", rx_buffer, 16'h1234);
      w1c(4'h2);
      chk("rx_overrun_flag", rx_overrun_flag, 1'b0);
      pop(16'h5A0F);
      for (i = 0; i < 5; i++) frame(16'h1100 + i[15:0]);
      for (i = 0; i < 4; i++) pop(16'h1100 + i[15:0]);
      chk("dma_rx_valid", dma_rx_valid, 1'b0);
      overwrite_when_full = 1'b1;
      for (i = 0; i < 5; i++) frame(16'h2200 + i[15:0]);
      for (i = 1; i < 5; i++) pop(16'h2200 + i[15:0]);
      chk("rx_buffer", rx_buffer, 16'h2204);
      rx_buffer_re = 1'b1;
      dma_cnt_one_to_zero = 1'b1;
      cyc(1);
      rx_buffer_re = 1'b0;
      dma_cnt_one_to_zero = 1'b0;
      chk("dma_irq", dma_irq, 1'b1);
      cyc(2);
      chk("rx_buffer_full_flag", rx_buffer_full_flag, 1'b0);
      frame(16'h3300);
      cyc(20);
      chk("dma_rx_valid", dma_rx_valid, 1'b0);
      dma_enable = 1'b0;
      dma_dir_tx = 1'b1;
      cyc(1);
      chk("tx_buffer_full_flag", tx_buffer_full_flag, 1'b0);
      dma_enable = 1'b1;
      cyc(1);
      chk("dma_tx_ready", dma_tx_ready, 1'b1);
      dma_tx_data = 16'h0F0F;
      dma_tx_valid = 1'b1;
      cyc(4);
      dma_tx_valid = 1'b0;
      chk("dma_tx_ready", dma_tx_ready, 1'b0);
      test_done();
   end
endmodule
`default_nettype wire
